// file: rtl/ballast_consts.svh
/*
 * Timing counts and thresholds for the lamp ballast mode sequencer.
 * Assumes a 40 MHz system clock; included by the design.
 */
`ifndef BALLAST_CONSTS_SVH
`define BALLAST_CONSTS_SVH

//------------------------------------------------------------------------
// Timing
//------------------------------------------------------------------------
`define CLK_PERIOD_PS      25000
`define PREHEAT_FREQ_HZ    75000
`define RUN_FREQ_HZ        42000
`define DEAD_TIME_NS       1000
// Half period in cycles, dead time rounded up.
`define PREHEAT_HALF_CYC   (40000000 / (2 * `PREHEAT_FREQ_HZ))
`define RUN_HALF_CYC       (40000000 / (2 * `RUN_FREQ_HZ))
`define DEAD_CYC           ((`DEAD_TIME_NS * 1000 + `CLK_PERIOD_PS - 1) \
                            / `CLK_PERIOD_PS)
`define OC_FAULT_LIMIT     25
`define CNT_W              12
`endif

// file: rtl/ballast_pkg.sv
/*
 * Types for the lamp ballast mode sequencer.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package ballast_pkg;
    typedef enum logic [2:0] {
        LOCKOUT,
        FILAMENT_HEAT,
        STRIKE,
        RUN,
        FAULT
    } mode_t;
    typedef enum logic [0:0] {
        PH_ON,
        PH_DEAD
    } phase_t;
endpackage

// file: rtl/ballast_mode_sequencer.sv
/*
 * Mode sequencer for a lamp ballast: lockout, filament heat, strike, run
 * and fault, with alternating half-bridge gates and an over-current count.
 * Assumes comparator flags arrive synchronous to CLK as clean levels.
 */
`timescale 1ns/1ps
`include "ballast_consts.svh"

module ballast_mode_sequencer #(
    parameter int PREHEAT_HALF = `PREHEAT_HALF_CYC,
    parameter int RUN_HALF     = `RUN_HALF_CYC,
    parameter int DEAD         = `DEAD_CYC,
    parameter int OC_LIMIT     = `OC_FAULT_LIMIT
) (
    // Clock and reset.
    input  wire logic CLK,
    input  wire logic RST_N,
    // Comparator flags.
    input  wire logic SUPPLY_START_OK,
    input  wire logic SUPPLY_TURNOFF,
    input  wire logic SHUTDOWN_INPUT_HIGH,
    input  wire logic PREHEAT_TIMER_DONE,
    input  wire logic CURRENT_SENSE_OVER,
    input  wire logic BUS_SENSE_LOW,
    input  wire logic LAMP_IGNITED,
    // Gate outputs.
    output logic      HIGH_SIDE_GATE,
    output logic      LOW_SIDE_GATE,
    output logic      BOOST_SWITCH_GATE,
    // Analog node controls and status.
    output logic      OSCILLATOR_TIMING_NODE_DISCHARGE,
    output logic      PREHEAT_TIMER_NODE_RESET,
    output logic      SUPPLY_PULL_DOWN,
    output logic [2:0] MODE
);

    localparam logic [`CNT_W-1:0] PH_HALF = `CNT_W'(PREHEAT_HALF);
    localparam logic [`CNT_W-1:0] RN_HALF = `CNT_W'(RUN_HALF);
    localparam logic [`CNT_W-1:0] DT      = `CNT_W'(DEAD);
    localparam logic [6:0]        OC_LIM  = 7'(OC_LIMIT);

    ballast_pkg::mode_t  mode_q, mode_d;
    ballast_pkg::phase_t phase_q, phase_d;
    logic [`CNT_W-1:0]   tmr_q, tmr_d;
    logic                low_next_q, low_next_d;
    logic [6:0]          oc_q, oc_d;
    logic                hs_q, hs_d, ls_q, ls_d, bst_q, bst_d;
    logic                pull_q, pull_d;
    logic                osc_run;
    logic                osc_next;
    logic                oc_event;
    logic [`CNT_W-1:0]   on_len;

    //--------------------------------------------------------------------
    // Mode, oscillator and counter
    //--------------------------------------------------------------------
    always_comb begin
        mode_d     = mode_q;
        phase_d    = phase_q;
        tmr_d      = tmr_q;
        low_next_d = low_next_q;
        oc_d       = oc_q;
        pull_d     = 1'b0;
        osc_run    = (mode_q == ballast_pkg::FILAMENT_HEAT) ||
                     (mode_q == ballast_pkg::STRIKE) ||
                     (mode_q == ballast_pkg::RUN);
        on_len     = (mode_q == ballast_pkg::RUN) ? (RN_HALF - DT)
                                                  : (PH_HALF - DT);
        // Only over-currents during the low-side on-time count.
        oc_event   = CURRENT_SENSE_OVER && ls_q;
        if (osc_run) begin
            if (tmr_q != '0) begin
                tmr_d = tmr_q - 1'b1;
            end else if (phase_q == ballast_pkg::PH_ON) begin
                phase_d    = ballast_pkg::PH_DEAD;
                tmr_d      = DT - 1'b1;
                low_next_d = ~low_next_q;
            end else begin
                phase_d = ballast_pkg::PH_ON;
                tmr_d   = on_len - 1'b1;
            end
        end
        case (mode_q)
            ballast_pkg::LOCKOUT: begin
                oc_d       = '0;
                phase_d    = ballast_pkg::PH_ON;
                low_next_d = 1'b1;
                tmr_d      = PH_HALF - DT - 1'b1;
                if (SUPPLY_START_OK && !SHUTDOWN_INPUT_HIGH) begin
                    mode_d = ballast_pkg::FILAMENT_HEAT;
                end
            end
            ballast_pkg::FILAMENT_HEAT, ballast_pkg::STRIKE: begin
                if (oc_event) begin
                    oc_d = oc_q + 1'b1;
                end
                if (oc_event && oc_q >= OC_LIM) begin
                    mode_d = ballast_pkg::FAULT;
                end else if (mode_q == ballast_pkg::FILAMENT_HEAT) begin
                    if (PREHEAT_TIMER_DONE) begin
                        mode_d = ballast_pkg::STRIKE;
                    end
                end else if (LAMP_IGNITED) begin
                    mode_d = ballast_pkg::RUN;
                end
            end
            ballast_pkg::RUN: begin
                if (CURRENT_SENSE_OVER) begin
                    mode_d = ballast_pkg::FAULT;
                end
            end
            ballast_pkg::FAULT: begin
                mode_d = ballast_pkg::FAULT;
            end
            default: begin
                mode_d = ballast_pkg::LOCKOUT;
            end
        endcase
        if (mode_q != ballast_pkg::LOCKOUT) begin
            if (SUPPLY_TURNOFF || SHUTDOWN_INPUT_HIGH) begin
                mode_d = ballast_pkg::LOCKOUT;
            end
            if (BUS_SENSE_LOW) begin
                mode_d = ballast_pkg::LOCKOUT;
                pull_d = 1'b1;
            end
        end
        // Gates are registered; both low outside oscillating modes.
        // They follow the next mode, so the first low-side pulse starts
        // in the same cycle as the mode change out of lockout.
        osc_next = (mode_d == ballast_pkg::FILAMENT_HEAT) ||
                   (mode_d == ballast_pkg::STRIKE) ||
                   (mode_d == ballast_pkg::RUN);
        hs_d  = osc_next && phase_d == ballast_pkg::PH_ON &&
                !low_next_d;
        ls_d  = osc_next && phase_d == ballast_pkg::PH_ON &&
                low_next_d;
        bst_d = osc_next;
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            mode_q     <= ballast_pkg::LOCKOUT;
            phase_q    <= ballast_pkg::PH_ON;
            tmr_q      <= '0;
            low_next_q <= 1'b1;
            oc_q       <= '0;
            hs_q       <= 1'b0;
            ls_q       <= 1'b0;
            bst_q      <= 1'b0;
            pull_q     <= 1'b0;
        end else begin
            mode_q     <= mode_d;
            phase_q    <= phase_d;
            tmr_q      <= tmr_d;
            low_next_q <= low_next_d;
            oc_q       <= oc_d;
            hs_q       <= hs_d;
            ls_q       <= ls_d;
            bst_q      <= bst_d;
            pull_q     <= pull_d;
        end
    end

    assign HIGH_SIDE_GATE    = hs_q;
    assign LOW_SIDE_GATE     = ls_q;
    assign BOOST_SWITCH_GATE = bst_q;
    assign SUPPLY_PULL_DOWN  = pull_q;
    assign MODE              = mode_q;
    // Timing node held discharged in lockout and fault.
    assign OSCILLATOR_TIMING_NODE_DISCHARGE =
        (mode_q == ballast_pkg::LOCKOUT) || (mode_q == ballast_pkg::FAULT);
    // Preheat timer held reset except while heating, striking or running.
    assign PREHEAT_TIMER_NODE_RESET =
        (mode_q == ballast_pkg::LOCKOUT) || (mode_q == ballast_pkg::FAULT);

    //--------------------------------------------------------------------
    // Checks
    //--------------------------------------------------------------------
    lockout_gates_a: assert property (@(posedge CLK) disable iff (!RST_N)
        mode_q == ballast_pkg::LOCKOUT |-> !hs_q && !ls_q &&
        OSCILLATOR_TIMING_NODE_DISCHARGE && PREHEAT_TIMER_NODE_RESET)
        else $error("gates active in lockout");
    start_cond_a: assert property (@(posedge CLK) disable iff (!RST_N)
        mode_q == ballast_pkg::LOCKOUT && SUPPLY_START_OK &&
        !SHUTDOWN_INPUT_HIGH |=> mode_q == ballast_pkg::FILAMENT_HEAT)
        else $error("lockout not left");
    first_low_a: assert property (@(posedge CLK) disable iff (!RST_N)
        mode_q == ballast_pkg::LOCKOUT ##1 mode_q ==
        ballast_pkg::FILAMENT_HEAT |-> ls_q && !hs_q)
        else $error("first pulse not low side");
    no_overlap_a: assert property (@(posedge CLK) disable iff (!RST_N)
        !(hs_q && ls_q))
        else $error("both gates high");
    dead_gap_a: assert property (@(posedge CLK) disable iff (!RST_N)
        $fell(ls_q) && osc_run && mode_q == $past(mode_q)
        |-> !hs_q [*2])
        else $error("dead time missing");
    heat_to_strike_a: assert property (@(posedge CLK) disable iff (!RST_N)
        mode_q == ballast_pkg::FILAMENT_HEAT && PREHEAT_TIMER_DONE &&
        !CURRENT_SENSE_OVER && !SUPPLY_TURNOFF && !SHUTDOWN_INPUT_HIGH &&
        !BUS_SENSE_LOW |=> mode_q == ballast_pkg::STRIKE)
        else $error("strike not entered");
    oc_count_a: assert property (@(posedge CLK) disable iff (!RST_N)
        (mode_q == ballast_pkg::FILAMENT_HEAT ||
         mode_q == ballast_pkg::STRIKE) && oc_event && oc_q >= OC_LIM &&
        !BUS_SENSE_LOW && !SUPPLY_TURNOFF && !SHUTDOWN_INPUT_HIGH
        |=> mode_q == ballast_pkg::FAULT)
        else $error("count fault missed");
    run_fault_a: assert property (@(posedge CLK) disable iff (!RST_N)
        mode_q == ballast_pkg::RUN && CURRENT_SENSE_OVER && !BUS_SENSE_LOW
        && !SUPPLY_TURNOFF && !SHUTDOWN_INPUT_HIGH
        |=> mode_q == ballast_pkg::FAULT)
        else $error("run fault missed");
    fault_low_a: assert property (@(posedge CLK) disable iff (!RST_N)
        mode_q == ballast_pkg::FAULT |-> !hs_q && !ls_q && !bst_q)
        else $error("gate high in fault");
    bus_low_a: assert property (@(posedge CLK) disable iff (!RST_N)
        mode_q != ballast_pkg::LOCKOUT && BUS_SENSE_LOW
        |=> mode_q == ballast_pkg::LOCKOUT && SUPPLY_PULL_DOWN && !hs_q)
        else $error("bus under-voltage ignored");
    fault_exit_a: assert property (@(posedge CLK) disable iff (!RST_N)
        mode_q == ballast_pkg::FAULT && !SUPPLY_TURNOFF &&
        !SHUTDOWN_INPUT_HIGH && !BUS_SENSE_LOW
        |=> mode_q == ballast_pkg::FAULT)
        else $error("fault left wrongly");
    oc_gate_a: assert property (@(posedge CLK) disable iff (!RST_N)
        !ls_q && mode_q == ballast_pkg::FILAMENT_HEAT |=> $stable(oc_q))
        else $error("counted outside low on-time");
    oc_clear_a: assert property (@(posedge CLK) disable iff (!RST_N)
        mode_q == ballast_pkg::LOCKOUT |=> oc_q == 7'h00)
        else $error("counter not cleared");

endmodule

// file: tb/ballast_switch_model.sv
/*
 * Half-bridge power stage model driven by the gate outputs.
 * Assumes gates are registered on CLK and sense is sampled on CLK.
 */
`timescale 1ns/1ps
module ballast_switch_model (
    // Clock.
    input  wire logic CLK,
    // Gates and disturbances.
    input  wire logic hs_on,
    input  wire logic ls_on,
    input  wire logic surge,
    input  wire logic stray,
    // Sense and health.
    output logic      cs_over,
    output logic      shoot
);
    initial shoot = 1'b0;
    // The sense resistor sits under the low-side switch only.
    assign cs_over = ls_on ? surge : stray;
    always @(posedge CLK) shoot <= shoot | (hs_on & ls_on);
endmodule

// file: tb/tb_ballast_mode_sequencer.sv
/*
 * Self-checking bench for the ballast mode sequencer.
 * Assumes shortened timing parameters and one 40 MHz clock.
 */
`timescale 1ns/1ps
module tb_ballast_mode_sequencer;
    localparam int PH = 20, RH = 30, DT = 4;
    logic clk = 0, rst_n = 0, start_ok = 0, turnoff = 0, sd = 1;
    logic tdone = 0, bus_low = 0, lit = 0, surge = 0, stray = 0;
    logic hs, ls, boost, dis, preset, pull, cs, shoot;
    logic [2:0] mode;
    int n_mismatch = 0, samples_checked = 0, seed = 29, n;
    always #12.5 clk = ~clk;
    ballast_mode_sequencer #(.PREHEAT_HALF(PH), .RUN_HALF(RH),
        .DEAD(DT), .OC_LIMIT(25)) i_dut (.CLK(clk), .RST_N(rst_n),
        .SUPPLY_START_OK(start_ok), .SUPPLY_TURNOFF(turnoff),
        .SHUTDOWN_INPUT_HIGH(sd), .PREHEAT_TIMER_DONE(tdone),
        .CURRENT_SENSE_OVER(cs), .BUS_SENSE_LOW(bus_low),
        .LAMP_IGNITED(lit), .HIGH_SIDE_GATE(hs), .LOW_SIDE_GATE(ls),
        .BOOST_SWITCH_GATE(boost), .OSCILLATOR_TIMING_NODE_DISCHARGE(dis),
        .PREHEAT_TIMER_NODE_RESET(preset), .SUPPLY_PULL_DOWN(pull),
        .MODE(mode));
    ballast_switch_model i_sw (.CLK(clk), .hs_on(hs), .ls_on(ls),
        .surge(surge), .stray(stray), .cs_over(cs), .shoot(shoot));
    //--------------------------------------------------------------------
    // Helpers
    //--------------------------------------------------------------------
    task automatic end_sim();
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %0t %s got %0h exp %0h", $time, what, got, exp);
        end
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task automatic span(input logic [1:0] pat, output int len);
        len = 0;
        while ({hs, ls} === pat && len < 900) begin
            tick(1);
            len++;
        end
    endtask
    task automatic wait_ls(input logic v);
        int g;
        g = 0;
        while (ls !== v && g < 900) begin
            tick(1);
            g++;
        end
        if (g >= 900) begin
            n_mismatch++;
            $display("BAD %0t low-side gate wait timed out", $time);
        end
    endtask
    task automatic wait_mode(input logic [2:0] m);
        int g;
        g = 0;
        while (mode !== m && g < 100) begin
            tick(1);
            g++;
        end
        chk(mode, m, "mode");
    endtask
    // One surge at the start of each of k low-side on-times.
    task automatic oc_events(input int k);
        repeat (k) begin
            wait_ls(1'b1);
            @(posedge clk) surge <= 1'b1;
            @(posedge clk) surge <= 1'b0;
            wait_ls(1'b0);
        end
    endtask
    initial begin
        repeat (30000) @(posedge clk);
        n_mismatch++;
        end_sim();
    end
    //--------------------------------------------------------------------
    // Scenarios
    //--------------------------------------------------------------------
    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk) start_ok <= 1'b1;
        tick(20);
        chk(mode, 0, "held by shutdown");
        chk({hs, ls, dis, preset}, 4'h3, "lockout outputs");
        @(posedge clk) sd <= 1'b0;
        wait_mode(3'h1);
        chk({dis, preset, boost}, 3'h1, "timer released, boost on");
        span(2'b00, n);
        chk(n, 0, "first pulse delay");
        chk({hs, ls}, 2'b01, "first pulse");
        stray <= 1'b1;
        span(2'b01, n);
        chk(n, PH - DT, "low on-time");
        span(2'b00, n);
        chk(n, DT, "dead time");
        span(2'b10, n);
        chk(n, PH - DT, "high on-time");
        oc_events(24);
        chk(mode, 1, "under limit");
        oc_events(2);
        wait_mode(3'h4);
        tick(3);
        chk({hs, ls, boost, dis, preset}, 5'h03, "fault outputs");
        @(posedge clk) tdone <= 1'b1;
        lit <= 1'b1;
        tick(10);
        chk(mode, 4, "fault holds");
        @(posedge clk) sd <= 1'b1;
        tdone <= 1'b0;
        lit <= 1'b0;
        stray <= 1'b0;
        wait_mode(3'h0);
        @(posedge clk) sd <= 1'b0;
        wait_mode(3'h1);
        n = 1 + ($unsigned($random(seed)) % 25);
        oc_events(n);
        chk(mode, 1, "count cleared");
        @(posedge clk) tdone <= 1'b1;
        wait_mode(3'h2);
        oc_events(25 - n);
        chk(mode, 2, "strike count");
        @(posedge clk) lit <= 1'b1;
        wait_mode(3'h3);
        wait_ls(1'b0);
        wait_ls(1'b1);
        wait_ls(1'b0);
        wait_ls(1'b1);
        span(2'b01, n);
        chk(n, RH - DT, "run on-time");
        oc_events(1);
        wait_mode(3'h4);
        @(posedge clk) turnoff <= 1'b1;
        wait_mode(3'h0);
        @(posedge clk) turnoff <= 1'b0;
        tdone <= 1'b0;
        lit <= 1'b0;
        wait_mode(3'h1);
        tick(30);
        @(posedge clk) bus_low <= 1'b1;
        tick(1);
        chk({pull, mode, hs, ls, boost}, 7'h40, "bus low");
        @(posedge clk) bus_low <= 1'b0;
        tick(2);
        chk({pull, shoot}, 0, "pulse and overlap");
        end_sim();
    end
endmodule
